//--- drjsc_top.sv
// Run/jog/stop state controller with speed command ramp and APB registers.
// Assumes control contacts and pulse inputs are synchronous to MCLK.
`timescale 1ns/1ns
module drjsc_top
	import drjsc_pkg::*;
#(
	parameter int TICK_COUNT = TICK_CYC
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic FAST_HALT_INPUT_N,
	input wire logic RAMP_HALT_INPUT_N,
	input wire logic RUN_REQUEST_INPUT_N,
	input wire logic JOG_REQUEST_INPUT_N,
	input wire logic FORMAT_SELECT_INPUT_N,
	input wire logic RAMP_DISABLE_N,
	input wire logic FEEDBACK_PULSE,
	input wire logic REFERENCE_PULSE,
	input wire logic OFFSET_PULSE,
	output logic [15:0] DRIVE_OUTPUT,
	output logic [3:0] STATE
);
	// Contacts are active low: a closure to common reads as zero.
	////////////////////////////////////////////////////////////////////////
	logic [23:0] div;
	logic tick;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div <= 24'h000000;
			tick <= 1'b0;
		end else begin
			tick <= (div == 24'(TICK_COUNT - 1));
			div <= (div == 24'(TICK_COUNT - 1)) ? 24'h000000 : div + 24'h000001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Sample the contacts once per tick so a state change sees one view.
	logic fast_ok, ramp_ok, run_req, jog_req, fmt_closed, ramp_off;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fast_ok <= 1'b0;
			ramp_ok <= 1'b0;
			run_req <= 1'b0;
			jog_req <= 1'b0;
			fmt_closed <= 1'b0;
			ramp_off <= 1'b0;
		end else if (tick) begin
			fast_ok <= ~FAST_HALT_INPUT_N;
			ramp_ok <= ~RAMP_HALT_INPUT_N;
			run_req <= ~RUN_REQUEST_INPUT_N;
			jog_req <= ~JOG_REQUEST_INPUT_N;
			fmt_closed <= ~FORMAT_SELECT_INPUT_N;
			ramp_off <= ~RAMP_DISABLE_N;
		end
	end
	logic step;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			step <= 1'b0;
		end else begin
			step <= tick;
		end
	end
	////////////////////////////////////////////////////////////////////////
	logic [15:0] fb_freq, ref_freq, ofs_freq;
	drjsc_freq #(.MIN_CYC(FB_MIN_CYC)) u_fb (.clk(MCLK), .rst_n(RESET_N),
		.pulse(FEEDBACK_PULSE), .tick(tick), .count(fb_freq));
	drjsc_freq #(.MIN_CYC(FB_MIN_CYC)) u_ref (.clk(MCLK), .rst_n(RESET_N),
		.pulse(REFERENCE_PULSE), .tick(tick), .count(ref_freq));
	drjsc_freq #(.MIN_CYC(OFS_MIN_CYC)) u_ofs (.clk(MCLK), .rst_n(RESET_N),
		.pulse(OFFSET_PULSE), .tick(tick), .count(ofs_freq));
	////////////////////////////////////////////////////////////////////////
	logic [31:0] ctrl;
	logic [15:0] setpt, ratio, jogpt, direct, offset, accel, decel;
	wire wr = PSEL & PENABLE & PWRITE;
	wire known = (PADDR[1:0] == 2'h0) && (PADDR <= A_REFFREQ);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~known;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl <= 32'h00000000;
			setpt <= SETPT_RST;
			ratio <= RATIO_ONE;
			jogpt <= SETPT_RST;
			direct <= SETPT_RST;
			offset <= SETPT_RST;
			accel <= RAMP_RST;
			decel <= RAMP_RST;
		end else if (wr) begin
			unique case (PADDR)
				A_CTRL: ctrl <= {30'h0, PWDATA[1:0]};
				A_SETPT: setpt <= PWDATA[15:0];
				A_RATIO: ratio <= PWDATA[15:0];
				A_JOGPT: jogpt <= PWDATA[15:0];
				A_DIRECT: direct <= PWDATA[15:0];
				A_OFFSET: offset <= PWDATA[15:0];
				A_ACCEL: accel <= clamp_ramp(PWDATA[15:0]);
				A_DECEL: decel <= clamp_ramp(PWDATA[15:0]);
				default: ;
			endcase
		end
	end
	function automatic logic [15:0] clamp_ramp(input logic [15:0] v);
		clamp_ramp = (v > 16'(RAMP_MAX_DS)) ? 16'(RAMP_MAX_DS) : v;
	endfunction
	////////////////////////////////////////////////////////////////////////
	drjsc_state_t state, next_state;
	always_comb begin
		next_state = state;
		if (!fast_ok) begin
			next_state = DRJSC_FSTOP;
		end else if (!ramp_ok) begin
			next_state = DRJSC_RSTOP;
		end else begin
			unique case (state)
				DRJSC_FSTOP: next_state = DRJSC_RSTOP;
				DRJSC_RSTOP: begin
					if (run_req && !jog_req) begin
						next_state = DRJSC_RUN;
					end else if (jog_req && !run_req) begin
						next_state = DRJSC_JOG;
					end
				end
				DRJSC_RUN: next_state = DRJSC_RUN;
				DRJSC_JOG: begin
					if (!jog_req) begin
						next_state = DRJSC_RSTOP;
					end
				end
				default: next_state = DRJSC_FSTOP;
			endcase
		end
	end
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= DRJSC_FSTOP;
		end else if (step) begin
			state <= next_state;
		end
	end
	assign STATE = state;
	////////////////////////////////////////////////////////////////////////
	drjsc_fmt_t fmt;
	assign fmt = ctrl[CTRL_REMAP] ?
		drjsc_fmt_t'({ctrl[CTRL_ALTFMT], fmt_closed}) :
		(fmt_closed ? DRJSC_FOLLOW : DRJSC_MASTER);
	wire [31:0] prod = ref_freq * ratio;
	wire [15:0] follow_cmd = sat16(prod >> RATIO_SHIFT);
	wire [15:0] offs_cmd = sat16(32'(follow_cmd) + 32'(offset)
		+ 32'(ofs_freq));
	logic [15:0] command;
	always_comb begin
		unique case (fmt)
			DRJSC_MASTER: command = setpt;
			DRJSC_FOLLOW: command = (ref_freq == 16'h0) ? 16'h0 : follow_cmd;
			DRJSC_DIRECT: command = direct;
			DRJSC_OFFSET: command = offs_cmd;
		endcase
		if (setpt == 16'h0 && fmt == DRJSC_MASTER) begin
			command = 16'h0;
		end
	end
	function automatic logic [15:0] sat16(input logic [31:0] v);
		sat16 = (v > 32'h0000ffff) ? 16'hffff : v[15:0];
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Ramped target moves one step per tick; a larger rate value is slower.
	logic [15:0] target, next_target;
	wire [15:0] goal = (state == DRJSC_JOG) ? jogpt :
		(state == DRJSC_RUN) ? command : 16'h0000;
	wire [15:0] up_step = rate_step(accel);
	wire [15:0] dn_step = rate_step(decel);
	function automatic logic [15:0] rate_step(input logic [15:0] r);
		rate_step = (r == 16'h0) ? 16'hffff : 16'(32'(RAMP_MAX_DS) / 32'(r));
	endfunction
	always_comb begin
		next_target = target;
		if (state == DRJSC_FSTOP || next_state == DRJSC_FSTOP) begin
			next_target = 16'h0;
		end else if (ramp_off || goal == target) begin
			next_target = goal;
		end else if (goal > target) begin
			next_target = (goal - target > up_step) ? target + up_step : goal;
		end else begin
			next_target = (target - goal > dn_step) ? target - dn_step : goal;
		end
	end
	// Closed-loop trim acts on the error between ramped target and speed.
	logic [15:0] trim;
	wire [16:0] err = {1'b0, target} - {1'b0, fb_freq};
	wire closed = (fmt != DRJSC_DIRECT);
	// Trim is frozen in ramp stop so the output falls at the decel rate.
	wire [15:0] trim_dn = (trim > 16'h1) ? trim - 16'h1 : 16'h0;
	wire [15:0] trim_up = (err[15:0] != 16'h0 && trim != 16'hffff) ?
		trim + 16'h1 : trim;
	wire [15:0] next_trim = err[16] ? trim_dn : trim_up;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			target <= 16'h0000;
			trim <= 16'h0000;
			DRIVE_OUTPUT <= 16'h0000;
		end else if (state == DRJSC_JOG && next_state != DRJSC_JOG && step) begin
			target <= 16'h0000;
			trim <= 16'h0000;
			DRIVE_OUTPUT <= 16'h0000;
		end else if (step) begin
			target <= next_target;
			if (!closed || next_target == 16'h0) begin
				trim <= 16'h0000;
				DRIVE_OUTPUT <= next_target;
			end else begin
				if (state != DRJSC_RSTOP) begin
					trim <= next_trim;
				end
				DRIVE_OUTPUT <= sat16(32'(next_target) + 32'(trim));
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	logic [31:0] rd;
	always_comb begin
		unique case (PADDR)
			A_CTRL: rd = ctrl;
			A_SETPT: rd = {16'h0, setpt};
			A_RATIO: rd = {16'h0, ratio};
			A_JOGPT: rd = {16'h0, jogpt};
			A_DIRECT: rd = {16'h0, direct};
			A_OFFSET: rd = {16'h0, offset};
			A_ACCEL: rd = {16'h0, accel};
			A_DECEL: rd = {16'h0, decel};
			A_STATUS: rd = {26'h0, fmt, state};
			A_OUTPUT: rd = {16'h0, DRIVE_OUTPUT};
			A_FBFREQ: rd = {16'h0, fb_freq};
			A_REFFREQ: rd = {16'h0, ref_freq};
			default: rd = 32'h00000000;
		endcase
	end
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rd;
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_jog_leave;
		state == DRJSC_JOG && step && next_state != DRJSC_JOG;
	endsequence
	chk_one_state: assert property (
		@(posedge MCLK) disable iff (!RESET_N) $onehot(state))
		else $error("State is not one-hot.");
	chk_run_entry: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		$rose(state == DRJSC_RUN) |-> $past(state) == DRJSC_RSTOP
		&& fast_ok && ramp_ok && !jog_req)
		else $error("Run entered from wrong state.");
	chk_jog_entry: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		$rose(state == DRJSC_JOG) |-> $past(state) == DRJSC_RSTOP
		&& !run_req)
		else $error("Jog entered from wrong state.");
	chk_jog_stop: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		s_jog_leave |=> DRIVE_OUTPUT == 16'h0)
		else $error("Output not zero after jog.");
	chk_fast_stop: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		!fast_ok && step |=> state == DRJSC_FSTOP && DRIVE_OUTPUT == 16'h0)
		else $error("Fast stop not immediate.");
	chk_ramp_state: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		fast_ok && !ramp_ok && step |=> state == DRJSC_RSTOP)
		else $error("Ramp stop state missed.");
	chk_ramp_down: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		step && state == DRJSC_RSTOP |=> target <= $past(target))
		else $error("Target rose in ramp stop.");
	chk_out_hold: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		!step |=> $stable(DRIVE_OUTPUT))
		else $error("Output moved between ticks.");
	chk_zero_setpt: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		step && state == DRJSC_RUN && fmt == DRJSC_MASTER && setpt == 16'h0
		&& target == 16'h0 |=> DRIVE_OUTPUT == 16'h0)
		else $error("Output with zero setpoint.");
	chk_tick_gap: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		tick |=> !tick)
		else $error("Tick pulse too long.");
endmodule

//--- drjsc_pkg.sv
// Constants, states and register map for the drive state controller.
// Assumes a 20 MHz system clock and an APB register bus.
package drjsc_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int RAMP_MAX_DS = 6000;
	localparam int FB_MAX_HZ = 30000;
	localparam int OFS_MAX_HZ = 10000;
	localparam int FB_MIN_CYC = CLK_HZ / FB_MAX_HZ;
	localparam int OFS_MIN_CYC = CLK_HZ / OFS_MAX_HZ;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SETPT = 8'h04;
	localparam logic [7:0] A_RATIO = 8'h08;
	localparam logic [7:0] A_JOGPT = 8'h0c;
	localparam logic [7:0] A_DIRECT = 8'h10;
	localparam logic [7:0] A_OFFSET = 8'h14;
	localparam logic [7:0] A_ACCEL = 8'h18;
	localparam logic [7:0] A_DECEL = 8'h1c;
	localparam logic [7:0] A_STATUS = 8'h20;
	localparam logic [7:0] A_OUTPUT = 8'h24;
	localparam logic [7:0] A_FBFREQ = 8'h28;
	localparam logic [7:0] A_REFFREQ = 8'h2c;
	localparam int CTRL_REMAP = 0;
	localparam int CTRL_ALTFMT = 1;
	localparam logic [15:0] SETPT_RST = 16'h0000;
	localparam logic [15:0] RATIO_ONE = 16'h0100;
	localparam int RATIO_SHIFT = 8;
	localparam logic [15:0] RAMP_RST = 16'h000a;
	typedef enum logic [3:0] {
		DRJSC_FSTOP = 4'b0001,
		DRJSC_RSTOP = 4'b0010,
		DRJSC_RUN = 4'b0100,
		DRJSC_JOG = 4'b1000
	} drjsc_state_t;
	typedef enum logic [1:0] {
		DRJSC_MASTER = 2'h0,
		DRJSC_FOLLOW = 2'h1,
		DRJSC_DIRECT = 2'h2,
		DRJSC_OFFSET = 2'h3
	} drjsc_fmt_t;
endpackage

//--- drjsc_freq.sv
// Pulse frequency meter: counts rising edges over one loop tick.
// Assumes the pulse input is already synchronous to the clock.
`timescale 1ns/1ns
module drjsc_freq
	import drjsc_pkg::*;
#(
	parameter int MIN_CYC = FB_MIN_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pulse,
	input wire logic tick,
	output logic [15:0] count
);
	logic prev;
	logic [15:0] acc;
	wire rise = pulse & ~prev;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
			acc <= 16'h0000;
			count <= 16'h0000;
		end else begin
			prev <= pulse;
			if (tick) begin
				count <= acc + 16'(rise);
				acc <= 16'h0000;
			end else if (rise && acc != 16'hffff) begin
				acc <= acc + 16'h0001;
			end
		end
	end
	// A 10 ms window at the top rate holds 300 edges; 16 bits is ample.
	localparam int MAX_EDGES = TICK_CYC / MIN_CYC;
	chk_count_bound: assert property (
		@(posedge clk) disable iff (!rst_n)
		tick |=> count <= 16'(MAX_EDGES * 4 + 1'b1))
		else $error("Frequency count above rated window.");
endmodule

//--- drjsc_switches.sv
// Operator contacts and pulse sensors on the far side of the controller.
// Assumes the bench sets the contact request and pulse periods at clk edges.
`timescale 1ns/1ns
module drjsc_switches (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] closed,
	input wire logic [7:0] ref_per,
	input wire logic [7:0] fb_per,
	input wire logic [7:0] ofs_per,
	output logic fast_n,
	output logic ramp_n,
	output logic run_n,
	output logic jog_n,
	output logic fmt_n,
	output logic rdis_n,
	output logic ref_pulse,
	output logic fb_pulse,
	output logic ofs_pulse
);
	logic [7:0] cnt [3];
	logic [7:0] per [3];
	logic [2:0] pls;
	////////////////////////////////////////////////////////////////////////
	// An open contact is pulled up, so a released line reads high.
	assign fast_n = ~closed[0];
	assign ramp_n = ~closed[1];
	assign run_n = ~closed[2];
	assign jog_n = ~closed[3];
	assign fmt_n = ~closed[4];
	assign rdis_n = ~closed[5];
	assign per[0] = ref_per;
	assign per[1] = fb_per;
	assign per[2] = ofs_per;
	assign ref_pulse = pls[0];
	assign fb_pulse = pls[1];
	assign ofs_pulse = pls[2];
	////////////////////////////////////////////////////////////////////////
	// A period of zero means a stopped sensor with no edges at all.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				cnt[i] <= 8'h00;
			end
			pls <= 3'b000;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (per[i] == 8'h00 || cnt[i] >= per[i] - 8'h01) begin
					cnt[i] <= 8'h00;
					pls[i] <= per[i] != 8'h00;
				end else begin
					cnt[i] <= cnt[i] + 8'h01;
					pls[i] <= 1'b0;
				end
			end
		end
	end
endmodule

//--- tb_top.sv
// Self-checking bench for the run/jog/stop controller.
// Assumes a short loop tick so that state changes come quickly.
`timescale 1ns/1ns
module tb_top;
	import drjsc_pkg::*;
	localparam int TK = 20;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] closed = 6'h00;
	logic [7:0] ref_per = 8'h00;
	logic [7:0] fb_per = 8'h00;
	logic [7:0] ofs_per = 8'h00;
	logic ofs_p;
	logic fast_n, ramp_n, run_n, jog_n, fmt_n, rdis_n, ref_p, fb_p;
	logic [15:0] drive;
	logic [3:0] state;
	logic [31:0] q;
	logic err;
	logic [15:0] o;
	int failures = 0;
	int total_checks = 0;
	always #25 mclk = ~mclk;
	drjsc_switches drjsc_switches_inst (.clk(mclk), .rst_n(reset_n),
		.closed(closed), .ref_per(ref_per), .fb_per(fb_per),
		.ofs_per(ofs_per), .fast_n(fast_n), .ramp_n(ramp_n),
		.run_n(run_n), .jog_n(jog_n), .fmt_n(fmt_n), .rdis_n(rdis_n),
		.ref_pulse(ref_p), .fb_pulse(fb_p), .ofs_pulse(ofs_p));
	drjsc_top #(.TICK_COUNT(TK)) drjsc_top_inst (.MCLK(mclk),
		.RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FAST_HALT_INPUT_N(fast_n),
		.RAMP_HALT_INPUT_N(ramp_n), .RUN_REQUEST_INPUT_N(run_n),
		.JOG_REQUEST_INPUT_N(jog_n), .FORMAT_SELECT_INPUT_N(fmt_n),
		.RAMP_DISABLE_N(rdis_n), .FEEDBACK_PULSE(fb_p),
		.REFERENCE_PULSE(ref_p), .OFFSET_PULSE(ofs_p),
		.DRIVE_OUTPUT(drive), .STATE(state));
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One edge passes first so a back-to-back call never reassigns psel.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			conclude();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge mclk);
	endtask
	task automatic wait_state(input drjsc_state_t s);
		int n;
		n = 0;
		while (state !== s && n < 5 * TK) begin
			@(posedge mclk);
			n++;
		end
		chk({28'h0, state}, {28'h0, s});
		if (n >= 5 * TK) begin
			conclude();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		chk({28'h0, state}, {28'h0, DRJSC_FSTOP});
		chk({16'h0, drive}, 32'h0);
		apb(1'b0, A_RATIO, 32'h0);
		chk(q, {16'h0, RATIO_ONE});
		apb(1'b0, A_ACCEL, 32'h0);
		chk(q, {16'h0, RAMP_RST});
		apb(1'b0, 8'h30, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, A_ACCEL, 32'h1770);
		apb(1'b1, A_DECEL, 32'h1770);
		closed <= 6'h01;
		wait_state(DRJSC_RSTOP);
		closed <= 6'h07;
		wait_state(DRJSC_RUN);
		closed <= 6'h03;
		ticks(3);
		chk({28'h0, state}, {28'h0, DRJSC_RUN});
		chk({16'h0, drive}, 32'h0);
		apb(1'b1, A_SETPT, 32'd1000);
		ticks(4);
		chk({31'h0, drive > 0 && drive < 20}, 32'h1);
		closed <= 6'h0b;
		ticks(2);
		chk({28'h0, state}, {28'h0, DRJSC_RUN});
		closed <= 6'h09;
		wait_state(DRJSC_RSTOP);
		o = drive;
		chk({31'h0, o != 0}, 32'h1);
		ticks(2);
		chk({31'h0, drive < o}, 32'h1);
		apb(1'b1, A_JOGPT, 32'd50);
		closed <= 6'h0b;
		wait_state(DRJSC_JOG);
		closed <= 6'h0f;
		ticks(2);
		chk({28'h0, state}, {28'h0, DRJSC_JOG});
		closed <= 6'h0b;
		ticks(3);
		chk({31'h0, drive > 0 && drive <= 50}, 32'h1);
		closed <= 6'h03;
		wait_state(DRJSC_RSTOP);
		chk({16'h0, drive}, 32'h0);
		closed <= 6'h07;
		wait_state(DRJSC_RUN);
		closed <= 6'h23;
		ticks(2);
		chk({31'h0, drive > 900}, 32'h1);
		closed <= 6'h00;
		wait_state(DRJSC_FSTOP);
		chk({16'h0, drive}, 32'h0);
		closed <= 6'h10;
		ticks(2);
		apb(1'b0, A_STATUS, 32'h0);
		chk({30'h0, q[5:4]}, {30'h0, DRJSC_FOLLOW});
		closed <= 6'h17;
		wait_state(DRJSC_RUN);
		ticks(3);
		chk({16'h0, drive}, 32'h0);
		ref_per <= 8'h04;
		fb_per <= 8'h04;
		ticks(3);
		apb(1'b0, A_REFFREQ, 32'h0);
		chk(q, 32'h5);
		apb(1'b0, A_FBFREQ, 32'h0);
		chk(q, 32'h5);
		chk({31'h0, drive > 0}, 32'h1);
		apb(1'b1, A_OFFSET, 32'd20);
		apb(1'b1, A_DIRECT, 32'd40);
		ofs_per <= 8'h05;
		apb(1'b1, A_CTRL, 32'h3);
		closed <= 6'h37;
		ticks(3);
		apb(1'b0, A_STATUS, 32'h0);
		chk({30'h0, q[5:4]}, {30'h0, DRJSC_OFFSET});
		chk({31'h0, drive >= 29 && drive < 40}, 32'h1);
		closed <= 6'h27;
		ticks(2);
		apb(1'b0, A_STATUS, 32'h0);
		chk({30'h0, q[5:4]}, {30'h0, DRJSC_DIRECT});
		chk({16'h0, drive}, 32'd40);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		chk({28'h0, state}, {28'h0, DRJSC_FSTOP});
		chk({16'h0, drive}, 32'h0);
		apb(1'b0, A_SETPT, 32'h0);
		chk(q, {16'h0, SETPT_RST});
		conclude();
	end
endmodule
